// ### rtl/serial_ctrl_consts.vh
/*
 * Constants for the serial unit control block: register byte offsets,
 * control field positions, reset values and baud timing figures.
 * Assumes inclusion by its bare name from the design file.
 */
// Function
// - Unit enable low disables unit and floats both serial pins.
// - Disable empties buffer, drops pending character, resets baud counter.
// - Disable clears enables, break, errors, receive-full; sets idle/empty flags.
// - Disable aborts transfers at once; re-enable resumes same configuration.
// - Unit active only with unit enable and serial mode select both set.
// - Nine-bit select picks 8 or 9 bit frames; ninth bits in own fields.
// - Parity enable switches parity generation and checking.
// - Parity odd select: 0 even parity, 1 odd parity.
// - Two-stop select: transmitter sends one or two stop bits.
// - Break send: finish buffered data, then low at least 13 bits until cleared.
// - Clearing transmitter enable aborts and resets transmitter, floats pin.
// - Transmit pin driven only with transmitter, unit and mode bits set.
// - Clearing receiver enable aborts and resets receiver and its buffer.
// - Receive pin sampled only with receiver, unit and mode bits set.
// - Baud high speed bit picks high or low speed with divisor.
// - With address detect, top data bit set marks address word, raises request.
// - With address detect, word with address bit clear is dropped silently.
// - Receive falling edge wakes only with clock stopped and wake enable set.
// - Receive irq enable routes overrun or receive-full onto the request.
// - Transmit-idle irq enable routes transmit-idle flag onto the request.
// - Transmit-empty irq enable routes transmit-empty flag onto the request.
// - Control bits reset to zero; receive ninth read-only, transmit ninth write-only.
// - Free running 8-bit baud timer: clock over 64 or 16 times divisor plus one.
// - Data sent and received LSB first, shared format and bit rate.
// - Status read then data access clears receive error flags.
`ifndef SERIAL_CTRL_CONSTS_VH
`define SERIAL_CTRL_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_FRAME_CTRL   8'h00
`define OFS_DIR_IRQ_CTRL 8'h04
`define OFS_STATUS       8'h08
`define OFS_DATA         8'h0c
`define OFS_BAUD_DIV     8'h10
`define OFS_MODE         8'h14

// ****************************************
// Field positions
// ****************************************
`define FC_UNIT_EN   7
`define FC_NINE      6
`define FC_PAR_EN    5
`define FC_PAR_ODD   4
`define FC_TWO_STOP  3
`define FC_BRK       2
`define FC_RX9       1
`define FC_TX9       0
`define DC_TX_EN     7
`define DC_RX_EN     6
`define DC_HS        5
`define DC_ADDR_EN   4
`define DC_WAKE_EN   3
`define DC_RX_IE     2
`define DC_TRANSMIT_IDLE_FLAG_IE  1
`define DC_TEMPTY_IE 0

// ****************************************
// Reset values and timing
// ****************************************
`define FRAME_CTRL_RST 8'h00
`define DIR_CTRL_RST   8'h00
`define BAUD_DIV_RST   8'h00
`define TICKS_LOW      7'd64
`define TICKS_HIGH     7'd16
`define BRK_BITS       4'd13

`endif

// ### rtl/serial_ctrl.v
/*
 * Serial unit control block: two control registers, status, data and
 * divisor registers on APB, baud generator, transmitter and receiver.
 * Assumes a 50 MHz mclk, rx_i synchronous to mclk, and an outside pad
 * that floats the pins when the enables are low.
 */
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "serial_ctrl_consts.vh"

module serial_ctrl (
	input  wire        mclk,        // System clock
	input  wire        rst_n,       // Async reset, active low
	input  wire [7:0]  paddr,       // APB address
	input  wire        psel,        // APB select
	input  wire        penable,     // APB enable
	input  wire        pwrite,      // APB direction
	input  wire [31:0] pwdata,      // APB write data
	output reg  [31:0] prdata,      // APB read data
	output wire        pready,      // APB ready
	output reg         pslverr,     // APB error, unmapped address
	output wire        tx_o,        // Transmit pin level
	output wire        tx_oe,       // Transmit pin drive enable
	input  wire        rx_i,        // Receive pin level
	output wire        rx_claim,    // Receive pin owned by unit
	input  wire        clk_stopped, // Fast clock stopped
	output wire        wake_req,    // Receive edge wake-up request
	output wire        irq          // Shared serial interrupt request
);

	// ****************************************
	// State codes
	// ****************************************
	localparam [5:0] T_IDLE  = 6'h01;
	localparam [5:0] T_START = 6'h02;
	localparam [5:0] T_DATA  = 6'h04;
	localparam [5:0] T_PAR   = 6'h08;
	localparam [5:0] T_STOP  = 6'h10;
	localparam [5:0] T_BRK   = 6'h20;
	localparam [4:0] R_IDLE  = 5'h01;
	localparam [4:0] R_START = 5'h02;
	localparam [4:0] R_DATA  = 5'h04;
	localparam [4:0] R_PAR   = 5'h08;
	localparam [4:0] R_STOP  = 5'h10;

	// ****************************************
	// Declarations
	// ****************************************
	reg  [7:0] fc_r;        // Frame control, rx9 and tx9 kept apart
	reg        rx9_r;
	reg  [7:0] dc_r;
	reg  [7:0] div_r;
	reg        mode_r;
	reg  [7:0] hold_r;
	reg        hold9_r;
	reg        hold_full_r;
	reg  [7:0] rdata_r;
	reg        receive_full_flag_r;
	reg        overrun_flag_r;
	reg        framing_flag_r;
	reg        parity_fail_flag_r;
	reg        nf_r;
	reg        stat_rd_r;
	reg        wake_r;
	reg        rx_prev_r;
	reg  [7:0] bcnt_r;
	reg  [5:0] t_st_r;
	reg  [6:0] t_ph_r;
	reg  [3:0] t_cnt_r;
	reg  [8:0] t_sh_r;
	reg        t_par_r;
	reg        line_r;
	reg  [4:0] r_st_r;
	reg  [6:0] r_ph_r;
	reg  [3:0] r_cnt_r;
	reg  [8:0] r_sh_r;
	reg        r_par_r;
	reg        r_parity_fail_flag_r;
	reg        r_nz_r;
	reg  [1:0] smp_r;
	wire       unit_en;
	wire       active;
	wire       tx_act;
	wire       rx_act;
	wire       tick;
	wire [6:0] per;
	wire [6:0] mid;
	wire       t_end;
	wire       r_evt;
	wire       r_bit;
	wire       r_noisy;
	wire [3:0] nbits;
	wire [8:0] word9;
	wire       addr_bit;
	wire       wr;
	wire       rd;
	wire       mapped;
	wire       data_acc;
	wire       transmit_idle_flag;
	wire       transmit_empty_flag;
	wire       receive_idle_flag;
	wire [7:0] status;
	wire       r_done;
	wire       r_keep;

	// ****************************************
	// Activity and pins
	// ****************************************
	assign unit_en  = fc_r[`FC_UNIT_EN];
	assign active   = unit_en & mode_r;
	assign tx_act   = active & dc_r[`DC_TX_EN];
	assign rx_act   = active & dc_r[`DC_RX_EN];
	assign tx_oe    = tx_act;
	assign tx_o     = line_r;
	assign rx_claim = rx_act;

	// Status flags
	assign transmit_empty_flag   = ~hold_full_r;
	assign transmit_idle_flag  = transmit_empty_flag & t_st_r[0] & ~fc_r[`FC_BRK];
	assign receive_idle_flag  = r_st_r[0];
	assign status = {parity_fail_flag_r, nf_r, framing_flag_r, overrun_flag_r, receive_idle_flag, receive_full_flag_r, transmit_idle_flag, transmit_empty_flag};

	// Shared request, OR of enabled sources
	assign irq = (dc_r[`DC_RX_IE] & (receive_full_flag_r | overrun_flag_r | wake_r))
		| (dc_r[`DC_TRANSMIT_IDLE_FLAG_IE] & transmit_idle_flag)
		| (dc_r[`DC_TEMPTY_IE] & transmit_empty_flag);
	assign wake_req = wake_r;

	// ****************************************
	// APB slave, zero wait states
	// ****************************************
	assign pready   = 1'b1;
	assign wr       = psel & penable & pwrite;
	assign rd       = psel & penable & ~pwrite;
	assign mapped   = (paddr == `OFS_FRAME_CTRL) | (paddr == `OFS_DIR_IRQ_CTRL)
		| (paddr == `OFS_STATUS) | (paddr == `OFS_DATA)
		| (paddr == `OFS_BAUD_DIV) | (paddr == `OFS_MODE);
	assign data_acc = psel & penable & (paddr == `OFS_DATA);

	// Read data and error latched in the setup cycle
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel & ~penable) begin
			pslverr <= ~mapped;
			case (paddr)
				`OFS_FRAME_CTRL:   prdata <= {24'h00_0000, fc_r[7:2], rx9_r, 1'b0};
				`OFS_DIR_IRQ_CTRL: prdata <= {24'h00_0000, dc_r};
				`OFS_STATUS:       prdata <= {24'h00_0000, status};
				`OFS_DATA:         prdata <= {24'h00_0000, rdata_r};
				`OFS_BAUD_DIV:     prdata <= {24'h00_0000, div_r};
				`OFS_MODE:         prdata <= {31'h0000_0000, mode_r};
				default:           prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Control registers; disable holds enables and break cleared
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fc_r   <= `FRAME_CTRL_RST;
			dc_r   <= `DIR_CTRL_RST;
			div_r  <= `BAUD_DIV_RST;
			mode_r <= 1'b0;
		end else begin
			if (wr && paddr == `OFS_FRAME_CTRL) begin
				fc_r <= {pwdata[7:2], 1'b0, pwdata[0]};
			end
			if (wr && paddr == `OFS_DIR_IRQ_CTRL) begin
				dc_r <= pwdata[7:0];
			end
			if (wr && paddr == `OFS_BAUD_DIV) begin
				div_r <= pwdata[7:0];
			end
			if (wr && paddr == `OFS_MODE) begin
				mode_r <= pwdata[0];
			end
			if (!unit_en) begin
				fc_r[`FC_BRK]   <= 1'b0;
				dc_r[`DC_TX_EN] <= 1'b0;
				dc_r[`DC_RX_EN] <= 1'b0;
			end
		end
	end

	// ****************************************
	// Baud generator
	// ****************************************
	assign per  = dc_r[`DC_HS] ? `TICKS_HIGH : `TICKS_LOW;
	assign mid  = {1'b0, per[6:1]};
	assign tick = (bcnt_r == 8'h00);

	// Free running divisor timer, reset while disabled
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bcnt_r <= 8'h00;
		end else if (!unit_en) begin
			bcnt_r <= 8'h00;
		end else if (tick) begin
			bcnt_r <= div_r;
		end else begin
			bcnt_r <= bcnt_r - 8'h01;
		end
	end

	assign nbits = fc_r[`FC_NINE] ? 4'd9 : 4'd8;

	// ****************************************
	// Transmitter
	// ****************************************
	assign t_end = tick & (t_ph_r == per - 7'd1);

	// Holding buffer loaded by data writes
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hold_r      <= 8'h00;
			hold9_r     <= 1'b0;
			hold_full_r <= 1'b0;
		end else if (!tx_act) begin
			hold_full_r <= 1'b0;
		end else if (wr && paddr == `OFS_DATA) begin
			hold_r      <= pwdata[7:0];
			hold9_r     <= fc_r[`FC_TX9];
			hold_full_r <= 1'b1;
		end else if (t_st_r[0]) begin
			hold_full_r <= 1'b0;
		end
	end

	// Transmit sequencer
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			t_st_r  <= T_IDLE;
			t_ph_r  <= 7'd0;
			t_cnt_r <= 4'd0;
			t_sh_r  <= 9'h000;
			t_par_r <= 1'b0;
			line_r  <= 1'b1;
		end else if (!tx_act) begin
			t_st_r <= T_IDLE;
			line_r <= 1'b1;
		end else begin
			if (tick) begin
				t_ph_r <= t_end ? 7'd0 : t_ph_r + 7'd1;
			end
			case (t_st_r)
				T_IDLE: begin
					line_r  <= 1'b1;
					t_ph_r  <= 7'd0;
					t_cnt_r <= 4'd0;
					if (hold_full_r) begin
						t_sh_r  <= {hold9_r, hold_r};
						t_par_r <= (fc_r[`FC_NINE] & hold9_r) ^ (^hold_r)
							^ fc_r[`FC_PAR_ODD];
						line_r  <= 1'b0;
						t_st_r  <= T_START;
					end else if (fc_r[`FC_BRK]) begin
						line_r <= 1'b0;
						t_st_r <= T_BRK;
					end
				end
				T_START: begin
					if (t_end) begin
						line_r <= t_sh_r[0];
						t_st_r <= T_DATA;
					end
				end
				T_DATA: begin
					if (t_end) begin
						t_sh_r  <= {1'b0, t_sh_r[8:1]};
						t_cnt_r <= t_cnt_r + 4'd1;
						if (t_cnt_r == nbits - 4'd1) begin
							t_cnt_r <= 4'd0;
							if (fc_r[`FC_PAR_EN]) begin
								line_r <= t_par_r;
								t_st_r <= T_PAR;
							end else begin
								line_r <= 1'b1;
								t_st_r <= T_STOP;
							end
						end else begin
							line_r <= t_sh_r[1];
						end
					end
				end
				T_PAR: begin
					if (t_end) begin
						line_r <= 1'b1;
						t_st_r <= T_STOP;
					end
				end
				T_STOP: begin
					if (t_end) begin
						if (fc_r[`FC_TWO_STOP] && t_cnt_r == 4'd0) begin
							t_cnt_r <= 4'd1;
						end else begin
							t_st_r <= T_IDLE;
						end
					end
				end
				T_BRK: begin
					line_r <= 1'b0;
					if (t_end && t_cnt_r != `BRK_BITS) begin
						t_cnt_r <= t_cnt_r + 4'd1;
					end
					if (t_cnt_r == `BRK_BITS && !fc_r[`FC_BRK]) begin
						line_r <= 1'b1;
						t_st_r <= T_IDLE;
					end
				end
				default: begin
					t_st_r <= T_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	assign r_evt    = tick & (r_ph_r == mid + 7'd1);
	assign r_bit    = (smp_r[0] & smp_r[1]) | (smp_r[0] & rx_i) | (smp_r[1] & rx_i);
	assign r_noisy  = ~((smp_r[0] == smp_r[1]) & (smp_r[1] == rx_i));
	assign r_done   = r_evt & r_st_r[4];
	assign word9    = fc_r[`FC_NINE] ? r_sh_r : {1'b0, r_sh_r[8:1]};
	assign addr_bit = fc_r[`FC_NINE] ? word9[8] : word9[7];
	assign r_keep   = ~dc_r[`DC_ADDR_EN] | addr_bit;

	// Receive sequencer with three-sample majority vote
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r_st_r   <= R_IDLE;
			r_ph_r   <= 7'd0;
			r_cnt_r  <= 4'd0;
			r_sh_r   <= 9'h000;
			r_par_r  <= 1'b0;
			r_parity_fail_flag_r <= 1'b0;
			r_nz_r   <= 1'b0;
			smp_r    <= 2'b11;
		end else if (!rx_act) begin
			r_st_r <= R_IDLE;
		end else begin
			if (tick) begin
				r_ph_r <= (r_ph_r == per - 7'd1) ? 7'd0 : r_ph_r + 7'd1;
				if (r_ph_r == mid - 7'd1) begin
					smp_r[0] <= rx_i;
				end
				if (r_ph_r == mid) begin
					smp_r[1] <= rx_i;
				end
			end
			if (r_evt && !r_st_r[0]) begin
				r_nz_r <= r_nz_r | r_noisy;
			end
			case (r_st_r)
				R_IDLE: begin
					r_ph_r <= 7'd0;
					if (rx_prev_r && !rx_i) begin
						r_cnt_r  <= 4'd0;
						r_par_r  <= 1'b0;
						r_parity_fail_flag_r <= 1'b0;
						r_nz_r   <= 1'b0;
						r_st_r   <= R_START;
					end
				end
				R_START: begin
					if (r_evt) begin
						r_st_r <= r_bit ? R_IDLE : R_DATA;
					end
				end
				R_DATA: begin
					if (r_evt) begin
						r_sh_r  <= {r_bit, r_sh_r[8:1]};
						r_par_r <= r_par_r ^ r_bit;
						r_cnt_r <= r_cnt_r + 4'd1;
						if (r_cnt_r == nbits - 4'd1) begin
							r_st_r <= fc_r[`FC_PAR_EN] ? R_PAR : R_STOP;
						end
					end
				end
				R_PAR: begin
					if (r_evt) begin
						r_parity_fail_flag_r <= (r_par_r ^ r_bit) != fc_r[`FC_PAR_ODD];
						r_st_r   <= R_STOP;
					end
				end
				R_STOP: begin
					if (r_evt) begin
						r_st_r <= R_IDLE;
					end
				end
				default: begin
					r_st_r <= R_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Receive buffer, flags and clear sequence
	// ****************************************
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r   <= 8'h00;
			rx9_r     <= 1'b0;
			receive_full_flag_r    <= 1'b0;
			overrun_flag_r    <= 1'b0;
			framing_flag_r    <= 1'b0;
			parity_fail_flag_r    <= 1'b0;
			nf_r      <= 1'b0;
			stat_rd_r <= 1'b0;
		end else if (!rx_act) begin
			receive_full_flag_r    <= 1'b0;
			overrun_flag_r    <= 1'b0;
			framing_flag_r    <= 1'b0;
			parity_fail_flag_r    <= 1'b0;
			nf_r      <= 1'b0;
			stat_rd_r <= 1'b0;
		end else begin
			if (rd && paddr == `OFS_STATUS) begin
				stat_rd_r <= 1'b1;
			end
			// Clear first so a same-cycle set wins
			if (data_acc && stat_rd_r) begin
				stat_rd_r <= 1'b0;
				overrun_flag_r    <= 1'b0;
				framing_flag_r    <= 1'b0;
				parity_fail_flag_r    <= 1'b0;
				nf_r      <= 1'b0;
				if (!pwrite) begin
					receive_full_flag_r <= 1'b0;
				end
			end
			if (r_done && r_keep) begin
				if (receive_full_flag_r && !(data_acc && stat_rd_r && !pwrite)) begin
					overrun_flag_r <= 1'b1;
				end else begin
					rdata_r <= word9[7:0];
					rx9_r   <= word9[8];
					receive_full_flag_r  <= 1'b1;
					framing_flag_r  <= ~r_bit;
					parity_fail_flag_r  <= r_parity_fail_flag_r & fc_r[`FC_PAR_EN];
					nf_r    <= r_nz_r | r_noisy;
				end
			end
		end
	end

	// ****************************************
	// Wake-up on receive falling edge
	// ****************************************
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_prev_r <= 1'b1;
			wake_r    <= 1'b0;
		end else begin
			rx_prev_r <= rx_i;
			if (!clk_stopped || !dc_r[`DC_WAKE_EN]) begin
				wake_r <= 1'b0;
			end else if (rx_prev_r && !rx_i) begin
				wake_r <= 1'b1;
			end
		end
	end

endmodule

// ### bench/serial_ctrl_properties.sv
/*
 * Checker for the serial control block, bound to its top module.
 * Assumes it sees only the top module ports, on the one mclk domain.
 */
`timescale 1ns/1ps
`include "serial_ctrl_consts.vh"

module serial_ctrl_properties (
	input wire        mclk,        // System clock
	input wire        rst_n,       // Async reset, active low
	input wire [7:0]  paddr,       // APB address
	input wire        psel,        // APB select
	input wire        penable,     // APB enable
	input wire        pwrite,      // APB direction
	input wire [31:0] pwdata,      // APB write data
	input wire [31:0] prdata,      // APB read data
	input wire        pready,      // APB ready
	input wire        pslverr,     // APB error
	input wire        tx_o,        // Transmit level
	input wire        tx_oe,       // Transmit drive enable
	input wire        rx_i,        // Receive level
	input wire        rx_claim,    // Receive pin owned
	input wire        clk_stopped, // Fast clock stopped
	input wire        wake_req,    // Wake-up request
	input wire        irq          // Shared interrupt request
);
	// ****************************************
	// Shadow of control bits
	// ****************************************
	reg       unit_r;
	reg       mode_r;
	reg [7:0] dir_r;
	wire      wr_acc = psel & penable & pwrite;

	// Track writes; unit off holds both direction enables cleared
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			unit_r <= 1'b0;
			mode_r <= 1'b0;
			dir_r  <= 8'h00;
		end else begin
			if (wr_acc && paddr == `OFS_FRAME_CTRL) unit_r <= pwdata[`FC_UNIT_EN];
			if (wr_acc && paddr == `OFS_MODE) mode_r <= pwdata[0];
			if (wr_acc && paddr == `OFS_DIR_IRQ_CTRL) dir_r <= pwdata[7:0];
			if (!unit_r || (wr_acc && paddr == `OFS_FRAME_CTRL && !pwdata[`FC_UNIT_EN]))
				dir_r[7:6] <= 2'b00;
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_disable;
		wr_acc && paddr == `OFS_FRAME_CTRL && !pwdata[`FC_UNIT_EN];
	endsequence
	sequence s_floating;
		(!tx_oe && !rx_claim) [*2];
	endsequence

	a_disable_floats: assert property (s_disable |=> s_floating)
		else $error("Pins still claimed after unit disable");
	a_tx_drive_gate: assert property (tx_oe == (unit_r && mode_r && dir_r[7]))
		else $error("Transmit drive does not follow enables");
	a_rx_sample_gate: assert property (rx_claim == (unit_r && mode_r && dir_r[6]))
		else $error("Receive claim does not follow enables");
	a_irq_all_masked: assert property (dir_r[2:0] == 3'b000 |-> !irq)
		else $error("Request raised with every source masked");
	a_irq_idle_source: assert property (!unit_r && dir_r[1:0] != 2'b00 |-> irq)
		else $error("Idle or empty source not on request");
	a_tx9_reads_zero: assert property (psel && penable && !pwrite
		&& paddr == `OFS_FRAME_CTRL |-> !prdata[`FC_TX9])
		else $error("Write-only ninth bit reads back");
	a_wake_needs_stop: assert property (!clk_stopped |=> !wake_req)
		else $error("Wake request with clock running");
	a_wake_needs_enable: assert property (!dir_r[`DC_WAKE_EN] |=> !wake_req)
		else $error("Wake request with wake disabled");
endmodule

// ### bench/serial_peer.sv
/*
 * Remote serial device on the transmit and receive lines.
 * Assumes the shared mclk and a bit length in clocks set by the bench.
 */
`timescale 1ns/1ps

module serial_peer (
	input  wire        mclk,     // System clock
	input  wire        line_in,  // Transmit line as seen remotely
	input  wire [7:0]  bit_len,  // Bit period in clocks
	output reg         line_out, // Receive line driven remotely
	output reg  [11:0] cap,      // Bit slots after last start
	output reg  [7:0]  cap_cnt   // Captures completed
);
	integer k;
	integer j;

	// Idle line high
	initial begin
		line_out = 1'b1;
		cap = 12'h000;
		cap_cnt = 8'h00;
	end

	// Sample twelve slots mid-bit after each start edge
	always begin
		@(negedge line_in);
		repeat (bit_len / 2) @(posedge mclk);
		for (k = 0; k < 12; k = k + 1) begin
			repeat (bit_len) @(posedge mclk);
			cap[k] = line_in;
		end
		cap_cnt = cap_cnt + 8'h01;
	end

	// Start, data LSB first, one stop, then a gap
	task send(input [8:0] w, input nine);
		begin
			@(posedge mclk) line_out <= 1'b0;
			repeat (bit_len) @(posedge mclk);
			for (j = 0; j < (nine ? 9 : 8); j = j + 1) begin
				line_out <= w[j];
				repeat (bit_len) @(posedge mclk);
			end
			line_out <= 1'b1;
			repeat (bit_len * 3) @(posedge mclk);
		end
	endtask
endmodule

// ### bench/serial_ctrl_bench.sv
/*
 * Self-checking bench for the serial control block: APB tasks, the
 * remote peer on the pins, register and frame scenarios.
 * Assumes the design, checker and peer are compiled before it.
 */
`timescale 1ns/1ps
`include "serial_ctrl_consts.vh"

module serial_ctrl_bench;
	reg         mclk;
	reg         rst_n;
	reg         psel;
	reg         penable;
	reg         pwrite;
	reg         clk_stopped;
	reg  [7:0]  paddr;
	reg  [31:0] pwdata;
	reg  [7:0]  bit_len;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire        tx_o;
	wire        tx_oe;
	wire        rx_line;
	wire        rx_claim;
	wire        wake_req;
	wire        irq;
	wire [11:0] cap;
	wire [7:0]  cap_cnt;
	wire        tx_line = tx_oe ? tx_o : 1'b1; // Pull-up when floating
	integer     error_cnt;
	integer     samples_checked;
	integer     i;
	reg  [31:0] rv;
	reg         re;
	reg  [7:0]  cnt0;
	reg  [39:0] fmt_tab;

	serial_ctrl DUT (
		.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_o(tx_o), .tx_oe(tx_oe), .rx_i(rx_line),
		.rx_claim(rx_claim), .clk_stopped(clk_stopped), .wake_req(wake_req), .irq(irq)
	);
	serial_peer peer (
		.mclk(mclk), .line_in(tx_line), .bit_len(bit_len), .line_out(rx_line),
		.cap(cap), .cap_cnt(cap_cnt)
	);

	// Clock
	always #10 mclk = ~mclk;

	// ****************************************
	// Tasks
	// ****************************************
	task chk(input string name, input [31:0] seen, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("mismatch %0s expected %h seen %h", name, exp, seen);
			end
		end
	endtask

	// One APB transfer; held until pready is sampled high
	task apb(input [7:0] a, input w, input [7:0] d);
		begin
			@(posedge mclk);
			psel <= 1'b1;
			penable <= 1'b0;
			paddr <= a;
			pwrite <= w;
			pwdata <= {24'h000000, d};
			@(posedge mclk);
			penable <= 1'b1;
			@(posedge mclk);
			while (pready !== 1'b1) @(posedge mclk);
			rv = prdata;
			re = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task wr(input [7:0] a, input [7:0] d);
		apb(a, 1'b1, d);
	endtask

	task rdc(input string n, input [7:0] a, input [7:0] exp);
		begin
			apb(a, 1'b0, 8'h00);
			chk(n, rv, {24'h000000, exp});
		end
	endtask

	// First frame bits then next start and data, twelve slots
	function [11:0] stream(input [7:0] f, input [7:0] d);
		reg [23:0] s;
		reg [8:0]  w;
		integer    n;
		integer    k;
		begin
			w = {f[`FC_TX9], d};
			n = f[`FC_NINE] ? 9 : 8;
			s = 24'h000000;
			for (k = 0; k < n; k = k + 1) s[k] = w[k];
			if (f[`FC_PAR_EN]) begin
				s[n] = (f[`FC_NINE] ? ^w : ^w[7:0]) ^ f[`FC_PAR_ODD];
				n = n + 1;
			end
			s[n] = 1'b1;
			n = n + 1;
			if (f[`FC_TWO_STOP]) begin
				s[n] = 1'b1;
				n = n + 1;
			end
			s = s | (s << (n + 1));
			stream = s[11:0];
		end
	endfunction

	// Two words back to back; compare the first frame and the next start and data
	task xmit(input [7:0] f, input [7:0] d);
		begin
			wr(`OFS_FRAME_CTRL, f);
			cnt0 = cap_cnt;
			wr(`OFS_DATA, d);
			wr(`OFS_DATA, d);
			while (cap_cnt == cnt0) @(posedge mclk);
			chk("tx_frame", {20'h00000, cap}, {20'h00000, stream(f, d)});
			do apb(`OFS_STATUS, 1'b0, 8'h00); while (rv[1] !== 1'b1);
			repeat (bit_len * 13) @(posedge mclk);
		end
	endtask

	// Cut a transmission short by a control write
	task abort(input [7:0] a, input [7:0] d);
		begin
			wr(`OFS_DATA, 8'h00);
			repeat (bit_len * 3) @(posedge mclk);
			wr(a, d);
			@(negedge mclk);
			chk("tx_oe", tx_oe, 1'b0);
			rdc("status", `OFS_STATUS, 8'h0b);
			repeat (bit_len * 13) @(posedge mclk);
		end
	endtask

	task conclude;
		begin
			if (error_cnt == 0 && samples_checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask

	// Watchdog
	initial begin
		#(20 * 60000);
		error_cnt = error_cnt + 1;
		conclude;
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		clk_stopped = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		bit_len = 8'd16;
		error_cnt = 0;
		samples_checked = 0;
		fmt_tab = 40'hc1b0a08880;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		rdc("frame", `OFS_FRAME_CTRL, 8'h00);
		rdc("dir", `OFS_DIR_IRQ_CTRL, 8'h00);
		rdc("status", `OFS_STATUS, 8'h0b);
		apb(8'h18, 1'b0, 8'h00);
		chk("unmapped", {31'h0, re}, 32'h1);
		wr(`OFS_DIR_IRQ_CTRL, 8'h03);
		@(negedge mclk);
		chk("irq_idle", irq, 1'b1);
		wr(`OFS_MODE, 8'h01);
		wr(`OFS_FRAME_CTRL, 8'h80);
		wr(`OFS_BAUD_DIV, 8'h00);
		wr(`OFS_DIR_IRQ_CTRL, 8'he0);
		rdc("dir", `OFS_DIR_IRQ_CTRL, 8'he0);
		for (i = 0; i < 5; i = i + 1) xmit(fmt_tab[i*8 +: 8], 8'ha5 ^ i);
		wr(`OFS_BAUD_DIV, 8'h01);
		bit_len = 8'd32;
		xmit(8'h80, 8'h96);
		wr(`OFS_BAUD_DIV, 8'h00);
		wr(`OFS_DIR_IRQ_CTRL, 8'hc0);
		bit_len = 8'd64;
		xmit(8'h80, 8'h69);
		wr(`OFS_DIR_IRQ_CTRL, 8'he4);
		bit_len = 8'd16;
		peer.send(9'h03c, 1'b0);
		chk("irq_rx", irq, 1'b1);
		rdc("status", `OFS_STATUS, 8'h0f);
		rdc("rx_data", `OFS_DATA, 8'h3c);
		peer.send(9'h011, 1'b0);
		peer.send(9'h022, 1'b0);
		rdc("status", `OFS_STATUS, 8'h1f);
		rdc("rx_data", `OFS_DATA, 8'h11);
		rdc("status", `OFS_STATUS, 8'h0b);
		wr(`OFS_DIR_IRQ_CTRL, 8'hf4);
		peer.send(9'h005, 1'b0);
		rdc("status", `OFS_STATUS, 8'h0b);
		peer.send(9'h085, 1'b0);
		chk("irq_addr", irq, 1'b1);
		rdc("status", `OFS_STATUS, 8'h0f);
		rdc("rx_data", `OFS_DATA, 8'h85);
		wr(`OFS_DIR_IRQ_CTRL, 8'he0);
		wr(`OFS_FRAME_CTRL, 8'hc0);
		peer.send(9'h15a, 1'b1);
		rdc("frame", `OFS_FRAME_CTRL, 8'hc2);
		rdc("rx_data", `OFS_DATA, 8'h5a);
		wr(`OFS_FRAME_CTRL, 8'h80);
		fork
			peer.send(9'h055, 1'b0);
			begin
				repeat (bit_len * 4) @(posedge mclk);
				wr(`OFS_DIR_IRQ_CTRL, 8'ha0);
			end
		join
		rdc("status", `OFS_STATUS, 8'h0b);
		wr(`OFS_DIR_IRQ_CTRL, 8'he0);
		wr(`OFS_FRAME_CTRL, 8'h84);
		repeat (bit_len * 13 + 8) @(posedge mclk);
		chk("break_low", tx_line, 1'b0);
		wr(`OFS_FRAME_CTRL, 8'h80);
		repeat (bit_len * 3) @(posedge mclk);
		chk("break_end", tx_line, 1'b1);
		abort(`OFS_DIR_IRQ_CTRL, 8'h60);
		wr(`OFS_DIR_IRQ_CTRL, 8'he0);
		abort(`OFS_FRAME_CTRL, 8'h00);
		rdc("dir", `OFS_DIR_IRQ_CTRL, 8'h20);
		wr(`OFS_FRAME_CTRL, 8'h80);
		wr(`OFS_DIR_IRQ_CTRL, 8'hec);
		xmit(8'h80, 8'h3c);
		peer.send(9'h000, 1'b0);
		chk("wake_run", wake_req, 1'b0);
		wr(`OFS_DIR_IRQ_CTRL, 8'hac);
		clk_stopped <= 1'b1;
		peer.send(9'h000, 1'b0);
		chk("wake_stop", wake_req, 1'b1);
		chk("irq_wake", irq, 1'b1);
		clk_stopped <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("wake_clr", wake_req, 1'b0);
		conclude;
	end
endmodule

bind serial_ctrl serial_ctrl_properties props (
	.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tx_o(tx_o), .tx_oe(tx_oe), .rx_i(rx_i), .rx_claim(rx_claim),
	.clk_stopped(clk_stopped), .wake_req(wake_req), .irq(irq)
);
